// file: logic/sdram_cfg_block.sv
/*
 * Configuration and decode part of an SDR SDRAM controller: self-refresh
 * dwell timer, four port QoS settings, chip-select decode and the user
 * bus width setting, all reached over AXI4-Lite.
 * Assumes one 100 MHz clock shared with the memory clock, a synchronous
 * active-low reset, and a sequencer outside that issues the memory commands.
 */
// Decided for this implementation: the AXI4-Lite slave port.
// Overview of operation
// - Memory stays in self-refresh for at least the programmed dwell count, reset 0x14.
// - Four QoS port registers serve CPU data, CPU instruction, display and second matrix.
// - Each port holds an 8-bit maximum QoS in bits 9:2, reset zero.
// - Bit 1 selects minimum mode, which takes priority over the maximum.
// - Bit 0 enables QoS for the port, reset disabled.
// - Chip select is asserted when masked address bits 31:24 equal the compare value.
// - A mask bit of one compares that address bit, zero ignores it.
// - Bit 16 selects bank-row-column order when set, row-bank-column when clear.
// - The write-only width bit selects 32-bit memory when set, 16-bit when clear.
`timescale 1ns/10ps
`include "sdram_cfg.svh"

module sdram_cfg_block #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] ahb_addr,
  output logic cs0_hit,
  output logic bank_first,
  output sdram_pkg::port_qos_t [3:0] port_qos,
  output logic sdr_wide,
  output logic [2:0] sdr_fixed_clock_field,
  input wire logic sr_enter,
  input wire logic wakeup_cmd,
  output logic sr_active,
  output logic sr_exit
);

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] sr_min_reg, sr_min_next;
  sdram_pkg::port_qos_t [3:0] qos_reg, qos_next;
  sdram_pkg::cs_decode_t cs_reg, cs_next;
  logic [2:0] clkf_reg, clkf_next;
  logic width_reg, width_next;
  logic [ADDR_W-1:0] aw_reg, aw_next;
  logic aw_have_reg, aw_have_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0] ws_reg, ws_next;
  logic wd_have_reg, wd_have_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;

  // Merges byte lanes of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Packs a QoS port into its register word
  function automatic logic [31:0] qos_word(input sdram_pkg::port_qos_t q);
    logic [31:0] r;
    r = 32'h00000000;
    r[`QOS_MAX_HI:`QOS_MAX_LO] = q.qos_max;
    r[`QOS_MIN_BIT] = q.qos_min;
    r[`QOS_EN_BIT] = q.qos_en;
    return r;
  endfunction

  // Tells whether an offset is a mapped register
  function automatic logic mapped(input logic [11:0] a);
    return a == `OFF_SR_MIN || a == `OFF_PORT0 || a == `OFF_PORT1 || a == `OFF_PORT2 ||
           a == `OFF_PORT3 || a == `OFF_CS0 || a == `OFF_USER || a == `OFF_STATUS;
  endfunction

  // ****************************************
  // Self-refresh dwell timer
  // ****************************************
  sdram_pkg::sr_state_t sr_state_reg, sr_state_next;
  logic [7:0] dwell_reg, dwell_next;

  // Counts the dwell from entry, then waits for the wakeup command
  always_comb begin
    sr_state_next = sr_state_reg;
    dwell_next = dwell_reg;
    sr_exit = 1'b0;
    case (sr_state_reg)
      sdram_pkg::SR_IDLE: begin
        if (sr_enter) begin
          sr_state_next = sdram_pkg::SR_DWELL;
          dwell_next = sr_min_reg;
        end
      end
      sdram_pkg::SR_DWELL: begin
        if (dwell_reg <= 8'h01) begin
          sr_state_next = sdram_pkg::SR_READY;
        end else begin
          dwell_next = dwell_reg - 8'h01;
        end
      end
      sdram_pkg::SR_READY: begin
        if (wakeup_cmd) begin
          sr_exit = 1'b1;
          sr_state_next = sdram_pkg::SR_IDLE;
        end
      end
      default: sr_state_next = sdram_pkg::SR_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_state_reg <= sdram_pkg::SR_IDLE;
      dwell_reg <= 8'h00;
    end else begin
      sr_state_reg <= sr_state_next;
      dwell_reg <= dwell_next;
    end
  end

  assign sr_active = sr_state_reg != sdram_pkg::SR_IDLE;

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  logic do_write;
  logic aw_got, wd_got;
  logic [31:0] old_word;
  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !wd_have_reg && !bvalid_reg;
  // Held-or-taken flags come straight from the handshake, so the write
  // decision never feeds back through the cleared next-state flags
  assign aw_got = aw_have_reg || s_axi_awvalid && s_axi_awready;
  assign wd_got = wd_have_reg || s_axi_wvalid && s_axi_wready;
  assign do_write = aw_got && wd_got && !bvalid_reg;

  // Current value of the addressed writable word
  always_comb begin
    case (aw_next)
      `OFF_SR_MIN: old_word = {24'h000000, sr_min_reg};
      `OFF_PORT0: old_word = qos_word(qos_reg[0]);
      `OFF_PORT1: old_word = qos_word(qos_reg[1]);
      `OFF_PORT2: old_word = qos_word(qos_reg[2]);
      `OFF_PORT3: old_word = qos_word(qos_reg[3]);
      `OFF_CS0: old_word = {15'h0000, cs_reg};
      `OFF_USER: old_word = {25'h0000000, clkf_reg, 3'h0, width_reg};
      default: old_word = 32'h00000000;
    endcase
  end

  // Captures address and data in either order, then writes and answers
  always_comb begin
    logic [31:0] w;
    w = 32'h00000000;
    aw_next = aw_have_reg ? aw_reg : s_axi_awaddr;
    aw_have_next = aw_got;
    wd_next = wd_have_reg ? wd_reg : s_axi_wdata;
    ws_next = wd_have_reg ? ws_reg : s_axi_wstrb;
    wd_have_next = wd_got;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    sr_min_next = sr_min_reg;
    qos_next = qos_reg;
    cs_next = cs_reg;
    clkf_next = clkf_reg;
    width_next = width_reg;
    if (do_write) begin
      w = merge(old_word, wd_next, ws_next);
      aw_have_next = 1'b0;
      wd_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = mapped(aw_next) ? 2'h0 : 2'h2;
      case (aw_next)
        `OFF_SR_MIN: sr_min_next = w[7:0];
        `OFF_PORT0, `OFF_PORT1, `OFF_PORT2, `OFF_PORT3: begin
          qos_next[aw_next[3:2]].qos_max = w[`QOS_MAX_HI:`QOS_MAX_LO];
          qos_next[aw_next[3:2]].qos_min = w[`QOS_MIN_BIT];
          qos_next[aw_next[3:2]].qos_en = w[`QOS_EN_BIT];
        end
        `OFF_CS0: begin
          cs_next.bank_first = w[`CS_ORDER_BIT];
          cs_next.match = w[`CS_MATCH_HI:`CS_MATCH_LO];
          cs_next.mask = w[`CS_MASK_HI:`CS_MASK_LO];
        end
        `OFF_USER: begin
          clkf_next = w[`USR_CLK_HI:`USR_CLK_LO];
          width_next = w[`USR_WIDTH_BIT];
        end
        default: bresp_next = 2'h2;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= '0;
      aw_have_reg <= 1'b0;
      wd_reg <= 32'h00000000;
      ws_reg <= 4'h0;
      wd_have_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      sr_min_reg <= `SR_MIN_RST;
      qos_reg <= '0;
      cs_reg <= {1'b0, `CS_MATCH_RST, `CS_MASK_RST};
      clkf_reg <= `USR_CLK_RST;
      width_reg <= 1'b0;
    end else begin
      aw_reg <= aw_next;
      aw_have_reg <= aw_have_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      wd_have_reg <= wd_have_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      sr_min_reg <= sr_min_next;
      qos_reg <= qos_next;
      cs_reg <= cs_next;
      clkf_reg <= clkf_next;
      width_reg <= width_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  assign s_axi_arready = !rvalid_reg;

  // Returns register contents; the user word is write-only and reads zero
  always_comb begin
    rvalid_next = rvalid_reg && !s_axi_rready;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      case (s_axi_araddr)
        `OFF_SR_MIN: rdata_next = {24'h000000, sr_min_reg};
        `OFF_PORT0: rdata_next = qos_word(qos_reg[0]);
        `OFF_PORT1: rdata_next = qos_word(qos_reg[1]);
        `OFF_PORT2: rdata_next = qos_word(qos_reg[2]);
        `OFF_PORT3: rdata_next = qos_word(qos_reg[3]);
        `OFF_CS0: rdata_next = {15'h0000, cs_reg};
        `OFF_STATUS: rdata_next = {22'h000000, dwell_reg, sr_state_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h00000000;
    end else begin
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // ****************************************
  // Decode and settings outputs
  // ****************************************
  // Masked compare of upper address byte
  assign cs0_hit = ((ahb_addr[31:24] ^ cs_reg.match) & cs_reg.mask) == 8'h00;
  assign bank_first = cs_reg.bank_first;
  assign port_qos = qos_reg;
  assign sdr_wide = width_reg;
  assign sdr_fixed_clock_field = clkf_reg;

  // ****************************************
  // Checks
  // ****************************************
  a_dwell_floor: assert property (@(posedge aclk) disable iff (!aresetn)
    sr_enter && sr_state_reg == sdram_pkg::SR_IDLE && sr_min_reg == 8'h03 |->
    ##1 sr_state_reg == sdram_pkg::SR_DWELL [*3] ##1 sr_state_reg == sdram_pkg::SR_READY)
    else $error("self-refresh dwell too short");
  a_exit_wakeup: assert property (@(posedge aclk) disable iff (!aresetn)
    sr_state_reg == sdram_pkg::SR_READY && !wakeup_cmd |=> sr_state_reg == sdram_pkg::SR_READY)
    else $error("left self-refresh without wakeup");
  a_cs_match: assert property (@(posedge aclk) disable iff (!aresetn)
    (ahb_addr[31:24] == cs_reg.match) |-> cs0_hit)
    else $error("exact match missed");
  a_mask_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (cs_reg.mask == 8'h00) |-> cs0_hit)
    else $error("empty mask must always hit");
  a_qos_store: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_next == `OFF_PORT2 && ws_next == 4'hF |->
    ##1 port_qos[2].qos_max == $past(wd_next[9:2]) && port_qos[2].qos_en == $past(wd_next[0]))
    else $error("port QoS not stored");
  a_qos_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_next == `OFF_PORT1 && ws_next[0] |->
    ##1 port_qos[1].qos_min == $past(wd_next[1]))
    else $error("QoS mode not stored");
  a_qos_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> port_qos[0].qos_en == 1'b0 && port_qos[3].qos_en == 1'b0)
    else $error("QoS enabled after reset");
  a_order_store: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_next == `OFF_CS0 && ws_next[2] |-> ##1 bank_first == $past(wd_next[16]))
    else $error("address order not stored");
  a_width_store: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_next == `OFF_USER && ws_next[0] |-> ##1 sdr_wide == $past(wd_next[0]))
    else $error("width not stored");
  a_ports_map: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_next == `OFF_PORT3 |-> ##1 $stable(port_qos[0]))
    else $error("port write leaked");
  c_sr_cycle: cover property (@(posedge aclk) disable iff (!aresetn) sr_exit);
  c_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
  c_hit: cover property (@(posedge aclk) disable iff (!aresetn) cs0_hit && cs_reg.mask != 8'h00);

endmodule

// file: logic/sdram_cfg.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * of the memory controller configuration block.
 * Assumes inclusion by bare name from the design and the bench.
 */
`ifndef SDRAM_CFG_SVH
`define SDRAM_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_SR_MIN 12'h048
`define OFF_PORT0 12'h100
`define OFF_PORT1 12'h104
`define OFF_PORT2 12'h108
`define OFF_PORT3 12'h10C
`define OFF_CS0 12'h200
`define OFF_USER 12'h304
`define OFF_STATUS 12'h308

// ****************************************
// Field positions and reset values
// ****************************************
`define SR_MIN_RST 8'h14
`define QOS_MAX_HI 9
`define QOS_MAX_LO 2
`define QOS_MIN_BIT 1
`define QOS_EN_BIT 0
`define CS_ORDER_BIT 16
`define CS_MATCH_HI 15
`define CS_MATCH_LO 8
`define CS_MASK_HI 7
`define CS_MASK_LO 0
`define CS_MATCH_RST 8'hFF
`define CS_MASK_RST 8'h00
`define USR_CLK_HI 6
`define USR_CLK_LO 4
`define USR_CLK_RST 3'h0
`define USR_WIDTH_BIT 0

`endif

// file: logic/sdram_pkg.sv
/*
 * Types shared by the memory controller configuration block.
 * Includes nothing; sdram_cfg.svh is not used here.
 */
package sdram_pkg;
  typedef struct packed {
    logic [7:0] qos_max;
    logic qos_min;
    logic qos_en;
  } port_qos_t;

  typedef struct packed {
    logic bank_first;
    logic [7:0] match;
    logic [7:0] mask;
  } cs_decode_t;

  typedef enum logic [1:0] {SR_IDLE, SR_DWELL, SR_READY} sr_state_t;
endpackage

// file: test/sdram_side_model.sv
/*
 * Far-side model: the command sequencer and memory that report entry into
 * self-refresh and carry the wakeup command back to the controller.
 * Assumes one clock shared with the block; the bench calls its tasks
 * right after a rising edge.
 */
`timescale 1ns/10ps

module sdram_side_model (
  input wire logic aclk,
  input wire logic sr_active,
  output logic sr_enter,
  output logic wakeup_cmd
);
  // Both strobes idle low from time zero
  initial begin
    sr_enter = 1'b0;
    wakeup_cmd = 1'b0;
  end

  // One-cycle pulse: memory has gone into self-refresh
  task automatic enter_sr();
    sr_enter <= 1'b1;
    @(posedge aclk);
    sr_enter <= 1'b0;
  endtask

  // Exit only by the wakeup command, never by the dwell running out
  task automatic start_wake();
    wakeup_cmd <= 1'b1;
  endtask

  task automatic stop_wake();
    wakeup_cmd <= 1'b0;
  endtask
endmodule

// file: test/sdram_cfg_block_bench.sv
/*
 * Self-checking bench for the configuration block: AXI4-Lite register
 * access, port QoS outputs, chip-select decode, user width setting and
 * the self-refresh dwell.
 * Assumes the design files compiled first and sdram_side_model on the far side.
 */
`timescale 1ns/10ps
`include "sdram_cfg.svh"

module sdram_cfg_block_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, ahb_addr = 32'h0, rd;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, cs0_hit, bank_first, sdr_wide;
  logic sr_enter, wakeup_cmd, sr_active, sr_exit;
  logic [2:0] clk_field;
  sdram_pkg::port_qos_t [3:0] pq;
  int failures = 0;
  int compares = 0;

  // ****************************************
  // Clock, design and far side
  // ****************************************
  always #5 aclk = ~aclk;

  sdram_cfg_block #(.ADDR_W(12)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ahb_addr(ahb_addr),
    .cs0_hit(cs0_hit), .bank_first(bank_first), .port_qos(pq), .sdr_wide(sdr_wide),
    .sdr_fixed_clock_field(clk_field), .sr_enter(sr_enter), .wakeup_cmd(wakeup_cmd),
    .sr_active(sr_active), .sr_exit(sr_exit));

  sdram_side_model model_u (.aclk(aclk), .sr_active(sr_active), .sr_enter(sr_enter),
    .wakeup_cmd(wakeup_cmd));

  // ****************************************
  // Compare and bus tasks
  // ****************************************
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: response got %h expected %h", $time, got, exp);
    end
  endtask

  // Handshakes are judged at the falling edge, acted on after the rising one
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        break;
      end
    end
    // Idle edge keeps bready from falling and rising in one step
    @(posedge aclk);
    chk_r(rs, er);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ha, hr;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) begin
        rready <= 1'b0;
        break;
      end
    end
    // Idle edge keeps rready from falling and rising in one step
    @(posedge aclk);
    chk_w(rd, ed);
    chk_r(rs, er);
  endtask

  task automatic report_and_stop();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog cuts a hang short
  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    report_and_stop();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic [31:0] q;
    logic [31:0] hits [4];
    hits = '{32'h4A000000, 32'h4F123456, 32'h50000000, 32'hC4000000};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(12'h048, 32'h14, 2'h0);
    rd_chk(12'h308, 32'h0, 2'h0);
    for (int i = 0; i < 4; i++) rd_chk(12'h100 + 12'(i * 4), 32'h0, 2'h0);
    rd_chk(12'h200, 32'h0000FF00, 2'h0);
    chk_w({29'h0, sdr_wide, bank_first, cs0_hit}, 32'h1);
    chk_w({29'h0, clk_field}, 32'h0);
    // Each port gets its own max value and mode pair, reserved bits zero
    for (int i = 0; i < 4; i++) begin
      q = {22'h0, 8'hFF - 8'(i * 8'h55), 2'(i)};
      wr(12'h100 + 12'(i * 4), q, 2'h0);
      rd_chk(12'h100 + 12'(i * 4), q, 2'h0);
      chk_w(32'(pq[i]), q);
    end
    // Low byte lane only: the top QoS bits keep their old value
    wstrb <= 4'h1;
    wr(12'h104, 32'h000003FF, 2'h0);
    wstrb <= 4'hF;
    rd_chk(12'h104, 32'h000002FF, 2'h0);
    // Compare top nibble only, bank-first order
    wr(12'h200, 32'h000140F0, 2'h0);
    chk_w({31'h0, bank_first}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      ahb_addr <= hits[i];
      @(negedge aclk);
      chk_w({31'h0, cs0_hit}, {31'h0, i < 2});
      @(posedge aclk);
    end
    // Master stays inside the configured chip-select area
    ahb_addr <= 32'h40000000;
    @(negedge aclk);
    chk_w({31'h0, cs0_hit}, 32'h1);
    @(posedge aclk);
    wr(12'h200, 32'h00004000, 2'h0);
    @(negedge aclk);
    chk_w({31'h0, cs0_hit}, 32'h1);
    @(posedge aclk);
    // Write-only user settings and an unmapped place
    wr(12'h304, 32'h11, 2'h0);
    chk_w({28'h0, clk_field, sdr_wide}, 32'h3);
    rd_chk(12'h304, 32'h0, 2'h0);
    wr(12'h304, 32'h10, 2'h0);
    chk_w({31'h0, sdr_wide}, 32'h0);
    wr(12'h0FC, 32'h0, 2'h2);
    rd_chk(12'h0FC, 32'h0, 2'h2);
    // Dwell of three cycles: wakeups inside it are ignored
    wr(12'h048, 32'h3, 2'h0);
    chk_w({31'h0, sr_active}, 32'h0);
    model_u.enter_sr();
    model_u.start_wake();
    @(negedge aclk);
    chk_w({30'h0, sr_active, sr_exit}, 32'h2);
    @(posedge aclk);
    model_u.stop_wake();
    @(posedge aclk);
    model_u.start_wake();
    @(negedge aclk);
    chk_w({30'h0, sr_active, sr_exit}, 32'h2);
    @(negedge aclk);
    chk_w({30'h0, sr_active, sr_exit}, 32'h3);
    @(posedge aclk);
    model_u.stop_wake();
    repeat (2) @(negedge aclk);
    chk_w({30'h0, sr_active, sr_exit}, 32'h0);
    @(posedge aclk);
    report_and_stop();
  end
endmodule
